// >>> cpe_cfg.svh
// Timing, scaling and code constants of the current to PWM encoder
`ifndef CPE_CFG_SVH
`define CPE_CFG_SVH

// Core clock rate and sampling slot
`define CPE_CLK_HZ       25000000
`define CPE_SLOT_MS      50
`define CPE_LEVELS       1024

// Cycles per ramp step; one ramp period is one sampling slot
`define CPE_STEP_CYCLES  (((`CPE_CLK_HZ / 1000) * `CPE_SLOT_MS) / `CPE_LEVELS)

// Field widths
`define CPE_CODE_W       10
`define CPE_ONES_W       11
`define CPE_SUM_W        21
`define CPE_DIV_W        11
`define CPE_PROD_W       43

// Duty codes: zero current, lower and upper full-scale limits; last ramp step
`define CPE_CODE_ZERO    10'h200
`define CPE_CODE_MIN     10'h02E
`define CPE_CODE_MAX     10'h3D1
`define CPE_RAMP_LAST    10'h3FF

// Fixed-point scaling of the slot sum into a duty code
`define CPE_RECIP_SHIFT  30
`define CPE_RECIP_ONE    32'h40000000
`define CPE_ROUND_HALF   43'h00020000000
`define CPE_CODE_LSB     30
`define CPE_OVF_LSB      40

`endif

// >>> cpe_pkg.sv
// Types shared by the current to PWM encoder modules
`include "cpe_cfg.svh"

package cpe_pkg;

   typedef logic [`CPE_CODE_W-1:0] cpe_code_t;
   typedef logic [`CPE_ONES_W-1:0] cpe_ones_t;
   typedef logic [`CPE_SUM_W-1:0]  cpe_sum_t;

   // Top-level operating states
   typedef enum logic [1:0] {
      CPE_ST_STRAP,
      CPE_ST_RUN,
      CPE_ST_HOLD
   } cpe_state_t;

endpackage

// >>> cpe_link_if.sv
// Internal carrier between the encoder top, its filter and its PWM stage
`timescale 1ns/10ps
`default_nettype none

interface cpe_link_if;
   logic                step_en;
   logic                half_en;
   logic                run;
   logic                mod_bit;
   cpe_pkg::cpe_ones_t  ones_cnt;
   logic                ones_valid;
   cpe_pkg::cpe_code_t  code;
   logic                code_valid;
   logic                pwm_high;
   logic                ramp_zero;

   modport filt (
      input  step_en,
      input  run,
      input  mod_bit,
      output ones_cnt,
      output ones_valid
   );

   modport pwm (
      input  step_en,
      input  half_en,
      input  run,
      input  code,
      input  code_valid,
      output pwm_high,
      output ramp_zero
   );

   modport ctrl (
      output step_en,
      output half_en,
      output run,
      output mod_bit,
      input  ones_cnt,
      input  ones_valid,
      output code,
      output code_valid,
      input  pwm_high,
      input  ramp_zero
   );
endinterface

`default_nettype wire

// >>> cpe_filter.sv
// First decimation stage: counts ones of the density stream per ramp step
`timescale 1ns/10ps
`default_nettype none
`include "cpe_cfg.svh"

module cpe_filter (
   input  wire logic clock,
   input  wire logic rst,
   cpe_link_if.filt  lnk
);

   cpe_pkg::cpe_ones_t cnt_q;
   cpe_pkg::cpe_ones_t cnt_d;
   cpe_pkg::cpe_ones_t total;

   // Running count including the current bit
   assign total = cnt_q + {{(`CPE_ONES_W-1){1'b0}}, lnk.mod_bit};
   assign cnt_d = lnk.step_en ? '0 : total;

   always_ff @(posedge clock) begin
      if (rst || !lnk.run) begin
         cnt_q          <= '0;
         lnk.ones_cnt   <= '0;
         lnk.ones_valid <= 1'b0;
      end else begin
         cnt_q          <= cnt_d;
         lnk.ones_valid <= lnk.step_en;
         if (lnk.step_en) begin
            lnk.ones_cnt <= total;
         end
      end
   end

endmodule

`default_nettype wire

// >>> cpe_pwm.sv
// Ramp comparator with half-step extension and wrap-aligned code load
`timescale 1ns/10ps
`default_nettype none
`include "cpe_cfg.svh"

module cpe_pwm (
   input  wire logic clock,
   input  wire logic rst,
   cpe_link_if.pwm   lnk
);

   cpe_pkg::cpe_code_t ramp_q;
   cpe_pkg::cpe_code_t active_q;
   logic               past_half_q;
   logic               above;
   logic               equal;

   assign above = active_q > ramp_q;
   assign equal = active_q == ramp_q;
   assign lnk.ramp_zero = ramp_q == '0;

   // extra half step when code equals ramp
   assign lnk.pwm_high = lnk.run && (above || (equal && !past_half_q));

   // Free-running ramp; wraps every 1024 steps
   always_ff @(posedge clock) begin
      if (rst || !lnk.run) begin
         ramp_q      <= '0;
         past_half_q <= 1'b0;
      end else begin
         if (lnk.step_en) begin
            ramp_q      <= ramp_q + 1'b1;
            past_half_q <= 1'b0;
         end else if (lnk.half_en) begin
            past_half_q <= 1'b1;
         end
      end
   end

   // load only in ramp step zero
   always_ff @(posedge clock) begin
      if (rst || !lnk.run) begin
         active_q <= `CPE_CODE_ZERO;
      end else if (lnk.code_valid && lnk.ramp_zero) begin
         active_q <= lnk.code;
      end
   end

endmodule

`default_nettype wire

// >>> cpe_top.sv
// Current to PWM encoder: density stream in, duty-cycle coded current out
`timescale 1ns/10ps
`default_nettype none
`include "cpe_cfg.svh"

module cpe_top #(
   parameter int unsigned STEP_CYCLES = `CPE_STEP_CYCLES
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 mod_bit_in,
   input  wire logic                 low_power_hold_n,
   input  wire logic                 full_scale_10a_in,
   output logic                      pwm_out_q,
   output logic                      running_q,
   output logic                      full_scale_10a_q,
   output cpe_pkg::cpe_code_t        current_code_q,
   output logic                      slot_done_q
);

   // Divider reload points and fixed-point reciprocal of one step
   localparam int unsigned STEP_LAST  = STEP_CYCLES - 1;
   localparam int unsigned HALF_LAST  = (STEP_CYCLES / 2) - 1;
   localparam int unsigned RECIP_I    = (`CPE_RECIP_ONE + (STEP_CYCLES / 2)) / STEP_CYCLES;
   localparam logic [`CPE_DIV_W-1:0]  DIV_LAST  = `CPE_DIV_W'(STEP_LAST);
   localparam logic [`CPE_DIV_W-1:0]  DIV_HALF  = `CPE_DIV_W'(HALF_LAST);
   localparam logic [`CPE_PROD_W-1:0] RECIP     = `CPE_PROD_W'(RECIP_I);

   cpe_link_if lnk ();

   // Pin synchronisers; first stage read only by second
   logic                    mod_s1_q;
   logic                    mod_s2_q;
   logic                    hold_s1_q;
   logic                    hold_s2_q;
   logic                    fs_s1_q;
   logic                    fs_s2_q;

   // Control state
   cpe_pkg::cpe_state_t     state_q;
   cpe_pkg::cpe_state_t     state_d;
   logic                    run;

   // Divider and slot accumulation
   logic [`CPE_DIV_W-1:0]   div_q;
   logic [`CPE_DIV_W-1:0]   div_d;
   logic                    div_wrap;
   logic                    div_half;
   cpe_pkg::cpe_code_t      step_idx_q;
   cpe_pkg::cpe_sum_t       sum_q;
   cpe_pkg::cpe_sum_t       sum_next;
   cpe_pkg::cpe_sum_t       slot_sum_q;
   logic                    slot_end;
   logic                    slot_end_q;

   // Code computation
   cpe_pkg::cpe_code_t      code_d;
   cpe_pkg::cpe_code_t      code_q;
   logic                    code_valid_q;

   // Scale a slot sum to a duty code with rounding and limit clamp
   function automatic cpe_pkg::cpe_code_t scale_code(
      input cpe_pkg::cpe_sum_t          sum,
      input logic [`CPE_PROD_W-1:0]     recip
   );
      logic [`CPE_PROD_W-1:0] prod;
      cpe_pkg::cpe_code_t     raw;
      prod = ({{(`CPE_PROD_W-`CPE_SUM_W){1'b0}}, sum} * recip) + `CPE_ROUND_HALF;
      raw  = prod[`CPE_CODE_LSB +: `CPE_CODE_W];
      if (prod[`CPE_PROD_W-1:`CPE_OVF_LSB] != '0) begin
         raw = `CPE_CODE_MAX;
      end
      if (raw > `CPE_CODE_MAX) begin
         raw = `CPE_CODE_MAX;
      end else if (raw < `CPE_CODE_MIN) begin
         raw = `CPE_CODE_MIN;
      end
      scale_code = raw;
   endfunction

   // Two-stage synchronisers for all pins; not reset, so the strap is valid at release
   always_ff @(posedge clock) begin
      mod_s1_q  <= mod_bit_in;
      mod_s2_q  <= mod_s1_q;
      hold_s1_q <= low_power_hold_n;
      hold_s2_q <= hold_s1_q;
      fs_s1_q   <= full_scale_10a_in;
      fs_s2_q   <= fs_s1_q;
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         cpe_pkg::CPE_ST_STRAP: begin
            state_d = cpe_pkg::CPE_ST_HOLD;
         end
         cpe_pkg::CPE_ST_RUN: begin
            if (!hold_s2_q) begin
               state_d = cpe_pkg::CPE_ST_HOLD;
            end
         end
         cpe_pkg::CPE_ST_HOLD: begin
            if (hold_s2_q) begin
               state_d = cpe_pkg::CPE_ST_RUN;
            end
         end
         default: begin
            state_d = cpe_pkg::CPE_ST_HOLD;
         end
      endcase
   end

   assign run = state_q == cpe_pkg::CPE_ST_RUN;

   // Strap state lasts one cycle after reset; the unreset synchronisers already hold the pins
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= cpe_pkg::CPE_ST_STRAP;
      end else begin
         state_q <= state_d;
      end
   end

   // full-scale option caught once after reset
   always_ff @(posedge clock) begin
      if (rst) begin
         full_scale_10a_q <= 1'b0;
      end else if (state_q == cpe_pkg::CPE_ST_STRAP) begin
         full_scale_10a_q <= fs_s2_q;
      end
   end

   // step divider sets a 20 Hz ramp period
   assign div_wrap = div_q == DIV_LAST;
   assign div_half = div_q == DIV_HALF;
   assign div_d    = div_wrap ? '0 : div_q + 1'b1;

   always_ff @(posedge clock) begin
      if (rst || !run) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   // Feed the filter and PWM stage
   assign lnk.step_en    = run && div_wrap;
   assign lnk.half_en    = run && div_half;
   assign lnk.run        = run;
   assign lnk.mod_bit    = mod_s2_q;
   assign lnk.code       = code_q;
   assign lnk.code_valid = code_valid_q;

   // slot is exactly one ramp period
   assign slot_end = lnk.ones_valid && (step_idx_q == `CPE_RAMP_LAST);
   assign sum_next = sum_q + {{(`CPE_SUM_W-`CPE_ONES_W){1'b0}}, lnk.ones_cnt};

   // Second decimation stage: sum of step counts over the slot
   always_ff @(posedge clock) begin
      if (rst || !run) begin
         step_idx_q <= '0;
         sum_q      <= '0;
         slot_sum_q <= '0;
         slot_end_q <= 1'b0;
      end else begin
         slot_end_q <= slot_end;
         if (lnk.ones_valid) begin
            step_idx_q <= step_idx_q + 1'b1;
            sum_q      <= slot_end ? '0 : sum_next;
         end
         if (slot_end) begin
            slot_sum_q <= sum_next;
         end
      end
   end

   // linear duty: code is density times 1024
   // round to nearest to keep the error unbiased
   assign code_d = scale_code(slot_sum_q, RECIP);

   // code of previous slot reaches PWM in next period
   always_ff @(posedge clock) begin
      if (rst || !run) begin
         code_q       <= `CPE_CODE_ZERO;
         code_valid_q <= 1'b0;
      end else begin
         code_valid_q <= slot_end_q;
         if (slot_end_q) begin
            code_q <= code_d;
         end
      end
   end

   cpe_filter u_filter (
      .clock (clock),
      .rst   (rst),
      .lnk   (lnk.filt)
   );

   cpe_pwm u_pwm (
      .clock (clock),
      .rst   (rst),
      .lnk   (lnk.pwm)
   );

   // registered 1024-level PWM; low in shutdown
   always_ff @(posedge clock) begin
      if (rst) begin
         pwm_out_q      <= 1'b0;
         running_q      <= 1'b0;
         current_code_q <= `CPE_CODE_ZERO;
         slot_done_q    <= 1'b0;
      end else begin
         pwm_out_q      <= run && lnk.pwm_high;
         running_q      <= run;
         slot_done_q    <= code_valid_q;
         if (!run) begin
            current_code_q <= `CPE_CODE_ZERO;
         end else if (code_valid_q) begin
            current_code_q <= code_q;
         end
      end
   end

endmodule

`default_nettype wire

// >>> cpe_top_props.sv
// Concurrent checks on the encoder top-level ports
`timescale 1ns/10ps
`default_nettype none
`include "cpe_cfg.svh"

module cpe_top_props #(
   parameter int unsigned STEP_CYCLES = `CPE_STEP_CYCLES
) (
   input wire logic               clock,
   input wire logic               rst,
   input wire logic               mod_bit_in,
   input wire logic               low_power_hold_n,
   input wire logic               full_scale_10a_in,
   input wire logic               pwm_out_q,
   input wire logic               running_q,
   input wire logic               full_scale_10a_q,
   input wire cpe_pkg::cpe_code_t current_code_q,
   input wire logic               slot_done_q
);
   localparam int SLOT = STEP_CYCLES * 1024;
   int   gap_q;
   int   hi_q;
   logic seen_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // Slot gap counter; first slot after a start is skipped, its phase is unknown
   always_ff @(posedge clock) begin
      if (rst || !running_q) begin
         gap_q  <= 0;
         seen_q <= 1'b0;
      end else if (slot_done_q) begin
         gap_q  <= 0;
         seen_q <= 1'b1;
      end else begin
         gap_q <= gap_q + 1;
      end
   end

   // Length of the current high run of the output
   always_ff @(posedge clock) begin
      if (rst || !pwm_out_q) begin
         hi_q <= 0;
      end else begin
         hi_q <= hi_q + 1;
      end
   end

   AST_SLOT_SPACING: assert property (
      slot_done_q && seen_q |-> gap_q == SLOT - 1)
      else $error("slot spacing wrong");
   AST_SLOT_PULSE: assert property (
      slot_done_q |=> !slot_done_q)
      else $error("slot pulse too long");
   AST_CODE_RANGE: assert property (
      current_code_q >= 10'h02E && current_code_q <= 10'h3D1)
      else $error("code outside limits");
   AST_HIGH_WIDTH: assert property (
      $fell(pwm_out_q) && running_q && low_power_hold_n
      |-> hi_q == current_code_q * STEP_CYCLES + STEP_CYCLES / 2)
      else $error("high time does not match code");
   AST_CODE_AT_SLOT: assert property (
      running_q && $past(running_q) && low_power_hold_n && $changed(current_code_q)
      |-> slot_done_q || $past(slot_done_q))
      else $error("code changed away from slot end");
   AST_HIGH_AT_WRAP: assert property (
      $rose(slot_done_q) |-> pwm_out_q && $past(pwm_out_q))
      else $error("output low at ramp start");
   AST_LOW_BEFORE_WRAP: assert property (
      $rose(slot_done_q) |-> !$past(pwm_out_q, 8))
      else $error("output high at ramp end");
   AST_HOLD_QUIET: assert property (
      !low_power_hold_n [*6] |-> !pwm_out_q && !running_q)
      else $error("active while held");
   AST_STRAP_STABLE: assert property (
      running_q |-> $stable(full_scale_10a_q))
      else $error("strap changed while running");

   COV_UPPER: cover property (slot_done_q && current_code_q == 10'h3D1);
   COV_LOWER: cover property (slot_done_q && current_code_q == 10'h02E);
   COV_HOLD:  cover property ($fell(running_q));
endmodule

`default_nettype wire

// >>> cpe_host_model.sv
// Host stand-in that times the high part of each PWM period
`timescale 1ns/10ps
`default_nettype none

module cpe_host_model (
   input  wire logic  clock,
   input  wire logic  rst,
   input  wire logic  pwm_in,
   output logic [15:0] high_cnt_q,
   output logic        strobe_q
);
   logic [15:0] cnt_q;
   logic        prev_q;

   // duty sampled per period, host scales and averages later
   always_ff @(posedge clock) begin
      prev_q <= pwm_in;
      if (rst) begin
         cnt_q    <= 16'h0000;
         strobe_q <= 1'b0;
      end else if (pwm_in && !prev_q) begin
         // raw count; the half step stays in, the consumer expects it
         high_cnt_q <= cnt_q; // Period just ended
         strobe_q   <= 1'b1;
         cnt_q      <= 16'h0001;
      end else begin
         strobe_q <= 1'b0;
         cnt_q    <= cnt_q + {15'h0000, pwm_in};
      end
   end
endmodule

`default_nettype wire

// >>> current_to_pwm_encoder_tb_top.sv
// Self-checking bench for the current to PWM encoder
`timescale 1ns/10ps
`default_nettype none

module current_to_pwm_encoder_tb_top;
   localparam int unsigned STEP = 4;
   logic               clock  = 1'b0;
   logic               rst    = 1'b1;
   logic               mod_bit = 1'b0;
   logic               hold_n = 1'b1;
   logic               strap  = 1'b1;
   logic [7:0]         pat    = 8'hAA;
   logic [2:0]         ph     = 3'h0;
   logic               pwm;
   logic               running;
   logic               fs_q;
   cpe_pkg::cpe_code_t code;
   logic               slot_done;
   logic [15:0]        host_high;
   logic               host_strobe;
   int                 fail_count = 0;
   int                 comparisons = 0;

   always #20 clock = ~clock;

   // Modulator stand-in; pattern period divides the slot so phase never matters
   always @(posedge clock) begin
      mod_bit <= pat[ph];
      ph      <= ph + 3'h1;
   end

   cpe_top #(.STEP_CYCLES(STEP)) dut (
      .clock(clock), .rst(rst), .mod_bit_in(mod_bit), .low_power_hold_n(hold_n),
      .full_scale_10a_in(strap), .pwm_out_q(pwm), .running_q(running),
      .full_scale_10a_q(fs_q), .current_code_q(code), .slot_done_q(slot_done));

   cpe_host_model u_host (
      .clock(clock), .rst(rst), .pwm_in(pwm), .high_cnt_q(host_high),
      .strobe_q(host_strobe));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic tick();
      @(posedge clock);
      #1;
   endtask

   // Bounded wait for a slot pulse or a host period report
   task automatic wait_pulse(input bit host);
      int n;
      n = 0;
      tick();
      while ((host ? host_strobe : slot_done) !== 1'b1 && n < 6000) begin
         tick();
         n++;
      end
      if (n >= 6000) begin
         fail_count++;
         $display("FAIL %0t: wait timed out", $time);
         complete_run();
      end
   endtask

   task automatic wait_run(input logic lvl);
      int n;
      n = 0;
      while (running !== lvl && n < 20) begin
         tick();
         n++;
      end
      if (n >= 20) begin
         fail_count++;
         $display("FAIL %0t: run wait timed out", $time);
         complete_run();
      end
   endtask

   task automatic sc_reset();
      tick();
      check({6'h00, code}, 16'h0200);
      check({15'h0000, pwm}, 16'h0000);
      @(posedge clock) rst <= 1'b0;
      wait_run(1'b1);
      check({15'h0000, fs_q}, 16'h0001);
   endtask

   // Balanced density in slot 0, half duty in the following period
   task automatic sc_first();
      wait_pulse(1'b0);
      check({6'h00, code}, 16'h0200);
      wait_pulse(1'b1);
      check(host_high, 16'(512 * STEP + STEP / 2));
   endtask

   // One full slot at a new density, then the period that shows it
   task automatic sc_level(input logic [7:0] p, input cpe_pkg::cpe_code_t c);
      @(posedge clock) pat <= p;
      wait_pulse(1'b0);
      wait_pulse(1'b0);
      check({6'h00, code}, {6'h00, c});
      wait_pulse(1'b1);
      check(host_high, 16'(c * STEP + STEP / 2));
   endtask

   task automatic sc_hold();
      @(posedge clock) hold_n <= 1'b0;
      repeat (8) tick();
      check({14'h0000, running, pwm}, 16'h0000);
      check({6'h00, code}, 16'h0200);
      @(posedge clock) hold_n <= 1'b1;
      wait_run(1'b1);
      check({15'h0000, running}, 16'h0001);
   endtask

   initial begin
      sc_reset();
      sc_first();
      sc_level(8'hFF, 10'h3D1);
      sc_level(8'h1F, 10'h280);
      sc_level(8'h07, 10'h180);
      sc_level(8'h00, 10'h02E);
      sc_hold();
      complete_run();
   end
endmodule

bind cpe_top cpe_top_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
   .clock(clock), .rst(rst), .mod_bit_in(mod_bit_in),
   .low_power_hold_n(low_power_hold_n), .full_scale_10a_in(full_scale_10a_in),
   .pwm_out_q(pwm_out_q), .running_q(running_q), .full_scale_10a_q(full_scale_10a_q),
   .current_code_q(current_code_q), .slot_done_q(slot_done_q));

`default_nettype wire
